// ### mfrs_fault_response.sv
// mfrs_fault_response: power stage response to stall, cycle and lock current-limit faults
// assumes synchronous sense inputs, one-cycle pwm_start pulses, an Avalon-MM master
//
// Summary of operation
// - stall fault raised on abnormal speed, missing motor or lost sync
// - stall mode 0000b/0001b: outputs high impedance, report, latch until clear
// - stall mode 0010b: high-side brake, report, latch until clear
// - stall mode 0011b: low-side brake, report, latch until clear
// - stall mode 0100b/0101b: high impedance, report, recover after retry time
// - stall mode 0110b: high-side brake, report, retry after retry time
// - stall mode 0111b: low-side brake, report, retry after retry time
// - stall 1000b reports only; 1xx1b neither reports nor acts
// - cycle limit 0000b/0001b: recirculate until next pwm cycle; 0000b reports
// - cycle limit 0010b/0011b: recirculate until sense falls; 0010b reports
// - cycle limit 0100b/0101b: recirculate until pwm count exceeds limit; 0100b reports
// - cycle limit 0110b reports only; 0111b and 1xxxb ignore the event
// - lock limit 0101b/0110b/0111b: recirculate/high/low brake, report, retry
// - latched lock limit responses hold until software clear
// - actionable stall and lock-limit faults always drive fault_n low; cycle-limit holds do so only in the reporting modes
// - priority latched, slower retry, faster retry, report only
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module mfrs_fault_response #(
   parameter int TICK_CYCLES = mfrs_pkg::RETRY_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [mfrs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [mfrs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [mfrs_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire mfrs_pkg::mfrs_sense_s sense,
   output mfrs_pkg::mfrs_stage_e stage_cmd,
   output logic fault_n
);
   import mfrs_pkg::*;

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // ************************************************************
   // lock mode decoder
   // ************************************************************
   function automatic mfrs_resp_s decode_lock(input logic [MODE_W-1:0] m, input logic lim);
      mfrs_resp_s r;
      r.report = 1'b0;
      r.retry = 1'b0;
      r.latch = 1'b0;
      r.act = STAGE_DRIVE;
      if (m[3]) begin
         r.report = ~m[0];
      end else begin
         r.report = 1'b1;
         r.retry = m[2];
         r.latch = ~m[2];
         case (m[1:0])
            2'b00: r.act = STAGE_HIZ;
            2'b01: r.act = lim ? STAGE_RECIRC : STAGE_HIZ;
            2'b10: r.act = STAGE_HS_BRAKE;
            default: r.act = STAGE_LS_BRAKE;
         endcase
      end
      return r;
   endfunction : decode_lock

   // ************************************************************
   // bus slave
   // ************************************************************
   logic ack_r, ack_nxt;
   logic waitreq_r;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [DATA_W-1:0] mode_cfg_r, mode_cfg_nxt;
   logic [DATA_W-1:0] retry_cfg_r, retry_cfg_nxt;
   logic [DATA_W-1:0] status_w;
   logic [NUM_FLAGS-1:0] flags_r, flags_nxt, flag_set;
   wire logic req = avs_read | avs_write;
   wire logic wr_go = ack_r & avs_write;
   wire logic sel_mode = avs_address == MODE_CFG_OFS;
   wire logic sel_retry = avs_address == RETRY_CFG_OFS;
   wire logic sel_flags = avs_address == FAULT_FLAGS_OFS;
   wire logic sel_clear = avs_address == FAULT_CLEAR_OFS;
   wire logic [DATA_W-1:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire logic [DATA_W-1:0] wbits = avs_writedata & wmask;
   wire logic clr = wr_go & sel_clear & wbits[CLEAR_BIT];

   assign ack_nxt = req & ~ack_r;
   assign mode_cfg_nxt = (wr_go && sel_mode) ? ((mode_cfg_r & ~wmask) | wbits) : mode_cfg_r;
   assign retry_cfg_nxt = (wr_go && sel_retry) ? ((retry_cfg_r & ~wmask) | wbits) : retry_cfg_r;
   assign rdata_nxt = !(ack_nxt && avs_read) ? rdata_r :
                      sel_mode ? mode_cfg_r :
                      sel_retry ? retry_cfg_r :
                      sel_flags ? status_w : '0;

   // bus never stalls on fault state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         waitreq_r <= 1'b1;
         rdata_r <= '0;
         mode_cfg_r <= MODE_CFG_RST;
         retry_cfg_r <= RETRY_CFG_RST;
      end else begin
         ack_r <= ack_nxt;
         waitreq_r <= ~ack_nxt;
         rdata_r <= rdata_nxt;
         mode_cfg_r <= mode_cfg_nxt;
         retry_cfg_r <= retry_cfg_nxt;
      end
   end

   wire logic [MODE_W-1:0] lock_fault_mode = mode_cfg_r[LOCK_MODE_LSB +: MODE_W];
   wire logic [MODE_W-1:0] cycle_limit_mode = mode_cfg_r[CYCLE_MODE_LSB +: MODE_W];
   wire logic [MODE_W-1:0] lock_limit_mode = mode_cfg_r[LIMIT_MODE_LSB +: MODE_W];
   wire logic [CNT_W-1:0] lock_retry_time = retry_cfg_r[RETRY_MS_LSB +: CNT_W];
   wire logic [CNT_W-1:0] cycle_limit_retry_count = retry_cfg_r[CYCLE_CNT_LSB +: CNT_W];

   // ************************************************************
   // retry time base
   // ************************************************************
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick_r;
   wire logic tick_wrap = tick_cnt_r == TICK_LAST;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 1'b1;
         tick_r <= tick_wrap;
      end
   end

   // ************************************************************
   // stall and lock-limit channels
   // ************************************************************
   wire logic stall_evt = sense.speed_abnormal | sense.motor_missing | sense.sync_lost;
   wire logic [1:0] ch_evt = {sense.lock_over, stall_evt};
   wire logic [1:0][MODE_W-1:0] ch_mode = {lock_limit_mode, lock_fault_mode};
   wire logic [CNT_W-1:0] retry_lim = (lock_retry_time == '0) ? CNT_W'(1) : lock_retry_time;
   mfrs_chan_e ch_state [2];
   mfrs_stage_e ch_act [2];
   mfrs_resp_s ch_resp [2];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         mfrs_chan_e state_r, state_nxt;
         mfrs_stage_e act_r, act_nxt;
         logic [CNT_W-1:0] tmr_r, tmr_nxt;
         assign ch_resp[g] = decode_lock(ch_mode[g], g == 1);
         assign ch_state[g] = state_r;
         assign ch_act[g] = act_r;

         always_comb begin
            state_nxt = state_r;
            act_nxt = act_r;
            tmr_nxt = tmr_r;
            case (state_r)
               CH_IDLE: begin
                  tmr_nxt = '0;
                  if (ch_evt[g] && ch_resp[g].latch) begin
                     state_nxt = CH_LATCH;
                     act_nxt = ch_resp[g].act;
                  end else if (ch_evt[g] && ch_resp[g].retry) begin
                     state_nxt = CH_RETRY;
                     act_nxt = ch_resp[g].act;
                  end
               end
               CH_RETRY: begin
                  // retry time counted in whole ticks
                  if (tick_r) begin
                     tmr_nxt = tmr_r + 1'b1;
                  end
                  if (tmr_r >= retry_lim) begin
                     state_nxt = CH_IDLE;
                     act_nxt = STAGE_DRIVE;
                  end
               end
               CH_LATCH: begin
                  if (clr) begin
                     state_nxt = CH_IDLE;
                     act_nxt = STAGE_DRIVE;
                  end
               end
               default: begin
                  state_nxt = CH_IDLE;
                  act_nxt = STAGE_DRIVE;
               end
            endcase
         end

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               state_r <= CH_IDLE;
               act_r <= STAGE_DRIVE;
               tmr_r <= '0;
            end else begin
               state_r <= state_nxt;
               act_r <= act_nxt;
               tmr_r <= tmr_nxt;
            end
         end
      end
   endgenerate

   // ************************************************************
   // cycle-by-cycle current limit
   // ************************************************************
   logic cyc_hold_r, cyc_hold_nxt;
   logic [CNT_W-1:0] cyc_cnt_r, cyc_cnt_nxt;
   wire logic [1:0] cyc_kind = cycle_limit_mode[2:1];
   wire logic cyc_act = ~cycle_limit_mode[3] & (cyc_kind != CYC_NO_ACT);
   wire logic cyc_rep = ~cycle_limit_mode[3] & ~cycle_limit_mode[0];

   always_comb begin
      cyc_hold_nxt = cyc_hold_r;
      cyc_cnt_nxt = cyc_cnt_r;
      if (!cyc_hold_r) begin
         cyc_cnt_nxt = '0;
         cyc_hold_nxt = sense.cycle_over & cyc_act;
      end else begin
         case (cyc_kind)
            CYC_NEXT_PWM: cyc_hold_nxt = ~sense.pwm_start;
            CYC_SENSE_LOW: cyc_hold_nxt = sense.cycle_over;
            CYC_PWM_COUNT: begin
               if (sense.pwm_start) begin
                  // released once the count passes the limit
                  if (cyc_cnt_r >= cycle_limit_retry_count) begin
                     cyc_hold_nxt = 1'b0;
                  end else begin
                     cyc_cnt_nxt = cyc_cnt_r + 1'b1;
                  end
               end
            end
            default: cyc_hold_nxt = 1'b0;
         endcase
      end
   end

   // ************************************************************
   // reporting, priority and outputs
   // ************************************************************
   assign flag_set[FLAG_STALL] = stall_evt & ch_resp[0].report;
   assign flag_set[FLAG_CYCLE] = sense.cycle_over & cyc_rep;
   assign flag_set[FLAG_LIMIT] = sense.lock_over & ch_resp[1].report;
   // a new event wins over a simultaneous clear
   assign flags_nxt = flag_set | (flags_r & ~{NUM_FLAGS{clr}});

   // latched first, then lock retry, then per-cycle recirculation
   wire mfrs_stage_e stage_nxt =
      (ch_state[0] == CH_LATCH) ? ch_act[0] :
      (ch_state[1] == CH_LATCH) ? ch_act[1] :
      (ch_state[0] == CH_RETRY) ? ch_act[0] :
      (ch_state[1] == CH_RETRY) ? ch_act[1] :
      cyc_hold_nxt ? STAGE_RECIRC : STAGE_DRIVE;

   wire logic actionable = (ch_state[0] != CH_IDLE) | (ch_state[1] != CH_IDLE) | cyc_hold_r;
   wire logic fault_n_nxt = ~(|flags_nxt | (actionable & cyc_rep) |
                              (ch_state[0] != CH_IDLE) | (ch_state[1] != CH_IDLE));

   // status word packed at the named field positions
   always_comb begin
      status_w = '0;
      status_w[FLAG_STALL +: NUM_FLAGS] = flags_r;
      status_w[STATE0_LSB +: $bits(mfrs_chan_e)] = ch_state[0];
      status_w[STATE1_LSB +: $bits(mfrs_chan_e)] = ch_state[1];
      status_w[CYC_HOLD_BIT] = cyc_hold_r;
      status_w[STAGE_LSB +: $bits(mfrs_stage_e)] = stage_cmd;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cyc_hold_r <= 1'b0;
         cyc_cnt_r <= '0;
         flags_r <= '0;
         stage_cmd <= STAGE_DRIVE;
         fault_n <= 1'b1;
      end else begin
         cyc_hold_r <= cyc_hold_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
         flags_r <= flags_nxt;
         stage_cmd <= stage_nxt;
         fault_n <= fault_n_nxt;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = waitreq_r;

endmodule : mfrs_fault_response

`default_nettype wire

// ### mfrs_pkg.sv
// mfrs_pkg: constants, types and register map of the motor fault response selector
// assumes a 10 MHz controller clock and 32-bit Avalon-MM register access
package mfrs_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_HZ = 10_000_000;
   localparam int RETRY_TICK_MS = 1;
   localparam int RETRY_TICK_CYCLES = CLK_HZ / 1000 * RETRY_TICK_MS;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] MODE_CFG_OFS = 4'h0;
   localparam logic [ADDR_W-1:0] RETRY_CFG_OFS = 4'h4;
   localparam logic [ADDR_W-1:0] FAULT_FLAGS_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] FAULT_CLEAR_OFS = 4'hC;

   // mode_cfg fields
   localparam int LOCK_MODE_LSB = 0;
   localparam int CYCLE_MODE_LSB = 4;
   localparam int LIMIT_MODE_LSB = 8;
   localparam int MODE_W = 4;
   localparam logic [DATA_W-1:0] MODE_CFG_RST = 32'h0000_0000;

   // retry_cfg fields
   localparam int RETRY_MS_LSB = 0;
   localparam int CYCLE_CNT_LSB = 8;
   localparam int CNT_W = 8;
   localparam logic [DATA_W-1:0] RETRY_CFG_RST = 32'h0000_0364;

   // fault_clear field
   localparam int CLEAR_BIT = 0;

   // controller_fault_flags fields
   localparam int FLAG_STALL = 0;
   localparam int FLAG_CYCLE = 1;
   localparam int FLAG_LIMIT = 2;
   localparam int NUM_FLAGS = 3;
   localparam int STATE0_LSB = 3;
   localparam int STATE1_LSB = 5;
   localparam int CYC_HOLD_BIT = 7;
   localparam int STAGE_LSB = 8;

   // ************************************************************
   // mode codes
   // ************************************************************
   localparam logic [1:0] CYC_NEXT_PWM = 2'h0;
   localparam logic [1:0] CYC_SENSE_LOW = 2'h1;
   localparam logic [1:0] CYC_PWM_COUNT = 2'h2;
   localparam logic [1:0] CYC_NO_ACT = 2'h3;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0] {
      STAGE_DRIVE = 3'h0,
      STAGE_HIZ = 3'h1,
      STAGE_RECIRC = 3'h2,
      STAGE_HS_BRAKE = 3'h3,
      STAGE_LS_BRAKE = 3'h4
   } mfrs_stage_e;

   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_RETRY = 2'b01,
      CH_LATCH = 2'b11
   } mfrs_chan_e;

   typedef struct packed {
      logic speed_abnormal;
      logic motor_missing;
      logic sync_lost;
      logic cycle_over;
      logic lock_over;
      logic pwm_start;
   } mfrs_sense_s;

   typedef struct packed {
      logic report;
      logic retry;
      logic latch;
      mfrs_stage_e act;
   } mfrs_resp_s;

endpackage : mfrs_pkg

// ### mfrs_fault_response_chk.sv
// mfrs_fault_response_chk: port-level assertions for the fault response block
// assumes one clk domain, one wait state per bus request, full-lane config writes
`timescale 1ns/1ps
`default_nettype none

module mfrs_fault_response_chk #(
   parameter int TICK_CYCLES = mfrs_pkg::RETRY_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [mfrs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [mfrs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [mfrs_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire mfrs_pkg::mfrs_sense_s sense,
   input wire mfrs_pkg::mfrs_stage_e stage_cmd,
   input wire logic fault_n
);
   import mfrs_pkg::*;

   // ************************************************************
   // shadow of the mode register, taken from accepted writes
   // ************************************************************
   logic [11:0] cfg_r;
   wire logic req = avs_read | avs_write;
   wire logic acc = avs_write & ~avs_waitrequest;
   wire logic cfg_acc = acc & (avs_address == MODE_CFG_OFS);
   wire logic clr_acc = acc & (avs_address == FAULT_CLEAR_OFS) & avs_writedata[CLEAR_BIT];
   wire logic [11:0] cfg_nxt = {avs_byteenable[1] ? avs_writedata[11:8] : cfg_r[11:8],
                                avs_byteenable[0] ? avs_writedata[7:0] : cfg_r[7:0]};
   wire logic stall_any = sense.speed_abnormal | sense.motor_missing | sense.sync_lost;
   wire logic [3:0] lk = cfg_r[3:0];
   // no retry or cycle hold can keep outputs away from drive after a clear
   wire logic quiet_cfg = (cfg_r[3:2] != 2'h1) & (cfg_r[11:10] != 2'h1) & cfg_r[7];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= 12'h000;
      end else if (cfg_acc) begin
         cfg_r <= cfg_nxt;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_req_acked: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait state");
   a_idle_quiet: assert property (!req && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped with no request");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_stall_hiz: assert property (stall_any && lk[3:1] == 3'h0 |-> ##[1:3] stage_cmd == STAGE_HIZ)
      else $error("stall latch did not float the outputs");
   a_stall_hsb: assert property (stall_any && lk == 4'h2 |-> ##[1:3] stage_cmd == STAGE_HS_BRAKE)
      else $error("stall latch did not apply high-side brake");
   a_stall_lsb: assert property (stall_any && lk == 4'h3 |-> ##[1:3] stage_cmd == STAGE_LS_BRAKE)
      else $error("stall latch did not apply low-side brake");
   a_stall_flag: assert property (stall_any && !lk[3] |-> ##[1:3] !fault_n)
      else $error("actionable stall not signalled on fault_n");
   a_cycle_recirc: assert property (sense.cycle_over && cfg_r[7:5] == 3'h0 && !stall_any
      && !sense.lock_over && stage_cmd == STAGE_DRIVE |-> ##[1:2] stage_cmd == STAGE_RECIRC)
      else $error("cycle limit did not recirculate");
   a_clear_release: assert property (clr_acc && sense[5:1] == 5'h00 && quiet_cfg
      |-> ##[1:3] (fault_n && stage_cmd == STAGE_DRIVE))
      else $error("clear did not release the outputs");

   c_stall_latch: cover property (stall_any && lk == 4'h0 ##3 stage_cmd == STAGE_HIZ);
   c_clear: cover property (clr_acc && quiet_cfg);
   c_recirc_end: cover property (stage_cmd == STAGE_RECIRC ##1 stage_cmd == STAGE_DRIVE);

endmodule : mfrs_fault_response_chk

bind mfrs_fault_response mfrs_fault_response_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense(sense),
   .stage_cmd(stage_cmd), .fault_n(fault_n));

`default_nettype wire

// ### mfrs_fault_response_tb.sv
// mfrs_fault_response_tb: table-driven bench for the fault response block
// assumes the bound checker and a short retry tick for simulation
`timescale 1ns/1ps
`default_nettype none

module mfrs_fault_response_tb;
   import mfrs_pkg::*;
   localparam int TICK = 10;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   mfrs_sense_s sense = '0;
   mfrs_stage_e stage_cmd;
   logic fault_n;
   logic [31:0] rd;
   int err_total = 0;
   int samples_checked = 0;
   // row: sense[29:24], mode_cfg[23:12], stage[10:8], fault_n[4], latched[0]
   logic [31:0] rows [31] = '{
      32'h2098_0101, 32'h1098_1101, 32'h0898_2301, 32'h2098_3401, 32'h2098_4100,
      32'h2098_5100, 32'h2098_6300, 32'h2098_7400, 32'h2098_8000, 32'h2098_9010,
      32'h2098_F010, 32'h0490_9200, 32'h0491_9210, 32'h0492_9200, 32'h0493_9210,
      32'h0494_9200, 32'h0495_9210, 32'h0496_9000, 32'h0497_9010, 32'h0498_9010,
      32'h0208_9101, 32'h0218_9201, 32'h0228_9301, 32'h0238_9401, 32'h0248_9100,
      32'h0258_9200, 32'h0268_9300, 32'h0278_9400, 32'h0288_9000, 32'h0298_9010,
      32'h02F8_9010};

   always #50 clk = ~clk;

   mfrs_fault_response #(.TICK_CYCLES(TICK)) uut (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense(sense),
      .stage_cmd(stage_cmd), .fault_n(fault_n));

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         err_total++;
      end
   endtask : chk

   // held until waitrequest is sampled low, then released
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) begin
         err_total++;
         conclude();
      end else begin
         avs_write <= 1'b0;
         avs_read <= 1'b0;
         @(posedge clk);
      end
   endtask : bus

   task automatic pwm;
      @(posedge clk);
      sense.pwm_start <= 1'b1;
      @(posedge clk);
      sense.pwm_start <= 1'b0;
   endtask : pwm

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, MODE_CFG_OFS, 32'h0, rd);
      chk(rd, MODE_CFG_RST);
      bus(1'b0, RETRY_CFG_OFS, 32'h0, rd);
      chk(rd, RETRY_CFG_RST);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
      bus(1'b0, 4'h2, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, MODE_CFG_OFS, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b1, RETRY_CFG_OFS, 32'h0000_0103, rd);
      foreach (rows[i]) begin
         bus(1'b1, MODE_CFG_OFS, {20'h0, rows[i][23:12]}, rd);
         sense <= rows[i][29:24];
         repeat (5) @(posedge clk);
         chk(stage_cmd, rows[i][10:8]);
         chk(fault_n, rows[i][4]);
         bus(1'b0, FAULT_FLAGS_OFS, 32'h0, rd);
         chk(rd[10:8], rows[i][10:8]);
         chk(rd[2:0], {rows[i][25], rows[i][26], |rows[i][29:27]} & {3{~rows[i][4]}});
         sense <= '0;
         repeat (4) pwm();
         repeat (50) @(posedge clk);
         chk(stage_cmd, rows[i][0] ? rows[i][10:8] : STAGE_DRIVE);
         bus(1'b1, FAULT_CLEAR_OFS, 32'h1, rd);
         repeat (3) @(posedge clk);
         chk(stage_cmd, STAGE_DRIVE);
         chk(fault_n, 1'b1);
         bus(1'b0, FAULT_FLAGS_OFS, 32'h0, rd);
         chk(rd, 32'h0);
      end
      // latched stall over limit retry, then latched limit over stall retry
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, MODE_CFG_OFS, k ? 32'h0000_0186 : 32'h0000_0482, rd);
         sense <= 6'h22;
         repeat (5) @(posedge clk);
         chk(stage_cmd, k ? STAGE_RECIRC : STAGE_HS_BRAKE);
         sense <= '0;
         repeat (60) @(posedge clk);
         chk(stage_cmd, k ? STAGE_RECIRC : STAGE_HS_BRAKE);
         bus(1'b1, FAULT_CLEAR_OFS, 32'h1, rd);
         repeat (3) @(posedge clk);
         chk(stage_cmd, STAGE_DRIVE);
      end
      // hold released only after count plus one pwm starts
      bus(1'b1, MODE_CFG_OFS, 32'h0000_0949, rd);
      sense <= 6'h04;
      @(posedge clk);
      sense <= '0;
      pwm();
      repeat (3) @(posedge clk);
      chk(stage_cmd, STAGE_RECIRC);
      pwm();
      repeat (3) @(posedge clk);
      chk(stage_cmd, STAGE_DRIVE);
      // event still present at the clear keeps its flag
      bus(1'b1, MODE_CFG_OFS, 32'h0000_0988, rd);
      sense <= 6'h20;
      repeat (3) @(posedge clk);
      bus(1'b1, FAULT_CLEAR_OFS, 32'h1, rd);
      bus(1'b0, FAULT_FLAGS_OFS, 32'h0, rd);
      chk(rd[2:0], 32'h1);
      sense <= '0;
      bus(1'b1, FAULT_CLEAR_OFS, 32'h1, rd);
      bus(1'b0, FAULT_FLAGS_OFS, 32'h0, rd);
      chk(rd, 32'h0);
      chk(fault_n, 1'b1);
      // mid-run reset drops a latched response
      bus(1'b1, MODE_CFG_OFS, 32'h0000_0980, rd);
      sense <= 6'h20;
      repeat (4) @(posedge clk);
      chk(stage_cmd, STAGE_HIZ);
      reset_n <= 1'b0;
      sense <= '0;
      repeat (2) @(posedge clk);
      chk(stage_cmd, STAGE_DRIVE);
      chk(fault_n, 1'b1);
      chk(avs_waitrequest, 1'b1);
      reset_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, MODE_CFG_OFS, 32'h0, rd);
      chk(rd, MODE_CFG_RST);
      bus(1'b0, FAULT_FLAGS_OFS, 32'h0, rd);
      chk(rd, 32'h0);
      conclude();
   end

endmodule : mfrs_fault_response_tb

`default_nettype wire
